// ==== bench/bscu_top_assertions.sv ====
// port-level checker for the barrel shifter and carry unit
`timescale 1ns/100ps

// ----------------------------------------
// checker
// ----------------------------------------
module bscu_check (
    input wire logic CLK_SYS, // core clock
    input wire logic RSTN, // reset, active low
    input wire logic SHIFT_VALID, // shift taken
    input wire logic [1:0] SHIFT_OP, // shift kind
    input wire logic SHIFT_FLAGGED, // flag form
    input wire logic [31:0] SHIFT_SRC, // source
    input wire logic [7:0] SHIFT_LEN, // length
    input wire logic SHIFT_DONE, // done pulse
    input wire logic [31:0] SHIFT_RESULT, // result
    input wire logic FLAGS_LOAD, // flag load
    input wire logic FLAG_CARRY, // carry
    input wire logic MEM_REQ, // access
    input wire logic [1:0] MEM_SIZE, // size
    input wire logic [31:0] MEM_ADDR, // address
    input wire logic MEM_GRANT, // grant pulse
    input wire logic FAULT_RAISE, // fault pulse
    input wire logic [31:0] INSTR_ADDR, // instruction
    input wire logic [31:0] PC_OPERAND, // pc as read
    input wire logic BRANCH_REQ, // branch
    input wire logic [1:0] BRANCH_KIND, // branch kind
    input wire logic LINK_WRITE, // link pulse
    input wire logic [31:0] LINK_VALUE // link value
);
    logic [31:0] src_q;
    logic [31:0] asr_q;
    logic [31:0] ia_q;
    logic [7:0] len_q;
    logic al_q;
    logic [1:0] up;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    // request fields kept a cycle, so no $past on indexed terms
    always_ff @(posedge CLK_SYS) begin
        src_q <= SHIFT_SRC;
        asr_q <= $signed(SHIFT_SRC) >>> SHIFT_LEN[4:0];
        len_q <= SHIFT_LEN;
        ia_q <= INSTR_ADDR;
        al_q <= MEM_SIZE[1] ? (MEM_ADDR[1:0] == 2'h0) : !(MEM_SIZE[0] & MEM_ADDR[0]);
    end

    // edges since release; outputs read zero while the reset copy drains
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end

    property p_zero;
        SHIFT_VALID && SHIFT_LEN == 8'h00 && !FLAGS_LOAD
            |=> SHIFT_DONE && SHIFT_RESULT == src_q && $stable(FLAG_CARRY);
    endproperty
    a_zero: assert property (p_zero) else $error("zero length changed value or carry");
    property p_shift;
        SHIFT_VALID && SHIFT_OP != 2'h3 && SHIFT_LEN < 8'h20 |=> SHIFT_RESULT ==
            ($past(SHIFT_OP) == 2'h0 ? asr_q : $past(SHIFT_OP) == 2'h1 ? src_q >> len_q : src_q << len_q);
    endproperty
    a_shift: assert property (p_shift) else $error("shift result wrong");
    property p_asr_big;
        SHIFT_VALID && SHIFT_OP == 2'h0 && SHIFT_LEN >= 8'h20
            |=> SHIFT_RESULT == {32{src_q[31]}} && (FLAG_CARRY == src_q[31] || !$past(SHIFT_FLAGGED));
    endproperty
    a_asr_big: assert property (p_asr_big) else $error("long arithmetic shift wrong");
    property p_right_c;
        SHIFT_VALID && SHIFT_FLAGGED && SHIFT_OP != 2'h2 && SHIFT_LEN inside {[8'h01:8'h20]}
            |=> FLAG_CARRY == src_q[len_q[5:0] - 6'h1];
    endproperty
    a_right_c: assert property (p_right_c) else $error("right carry wrong");
    property p_left_c;
        SHIFT_VALID && SHIFT_FLAGGED && SHIFT_OP == 2'h2 && SHIFT_LEN inside {[8'h01:8'h20]}
            |=> FLAG_CARRY == src_q[6'h20 - len_q[5:0]];
    endproperty
    a_left_c: assert property (p_left_c) else $error("left carry wrong");
    property p_logic_big;
        SHIFT_VALID && SHIFT_OP inside {2'h1, 2'h2} && SHIFT_LEN >= 8'h20 |=> SHIFT_RESULT == 32'h0
            && (len_q == 8'h20 || !$past(SHIFT_FLAGGED) || !FLAG_CARRY);
    endproperty
    a_logic_big: assert property (p_logic_big) else $error("long logical shift wrong");
    property p_rot;
        SHIFT_VALID && SHIFT_OP == 2'h3
            |=> SHIFT_RESULT == ((src_q >> len_q[4:0]) | (src_q << (6'h20 - len_q[4:0])));
    endproperty
    a_rot: assert property (p_rot) else $error("rotate result wrong");
    property p_align;
        MEM_REQ && !BRANCH_REQ |=> MEM_GRANT == al_q && FAULT_RAISE == !al_q;
    endproperty
    a_align: assert property (p_align) else $error("alignment verdict wrong");
    property p_pc;
        up == 2'h3 |-> PC_OPERAND == ia_q + 32'h4;
    endproperty
    a_pc: assert property (p_pc) else $error("program counter operand wrong");
    property p_link;
        BRANCH_REQ && BRANCH_KIND == 2'h3 |=> LINK_WRITE && LINK_VALUE == ((ia_q + 32'h4) | 32'h1);
    endproperty
    a_link: assert property (p_link) else $error("link value wrong");

    c_flag_shift: cover property (SHIFT_VALID && SHIFT_FLAGGED && SHIFT_LEN > 8'h20);
    c_mem_fault: cover property (MEM_REQ ##1 FAULT_RAISE);
    c_link: cover property (LINK_WRITE);
endmodule

bind bscu_top bscu_check u_check (.CLK_SYS, .RSTN, .SHIFT_VALID, .SHIFT_OP, .SHIFT_FLAGGED,
    .SHIFT_SRC, .SHIFT_LEN, .SHIFT_DONE, .SHIFT_RESULT, .FLAGS_LOAD, .FLAG_CARRY, .MEM_REQ,
    .MEM_SIZE, .MEM_ADDR, .MEM_GRANT, .FAULT_RAISE, .INSTR_ADDR, .PC_OPERAND, .BRANCH_REQ,
    .BRANCH_KIND, .LINK_WRITE, .LINK_VALUE);

// ==== bench/tb_barrel_shifter_carry_unit.sv ====
// self-checking testbench of the barrel shifter and carry unit
`timescale 1ns/100ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
    $display("ERROR %0t: got %h expected %h", $time, a, b); end end

// ----------------------------------------
// testbench
// ----------------------------------------
module tb_barrel_shifter_carry_unit;
    logic CLK_SYS = 1'b0, RSTN = 1'b0, SHIFT_VALID = 1'b0, SHIFT_FLAGGED = 1'b0;
    logic FLAGS_LOAD = 1'b0, MEM_REQ = 1'b0, BRANCH_REQ = 1'b0, FAULT_ACK = 1'b0;
    logic [1:0] SHIFT_OP = 2'h0, MEM_SIZE = 2'h0, BRANCH_KIND = 2'h0;
    logic [2:0] FLAGS_IN = 3'h0;
    logic [7:0] SHIFT_LEN = 8'h00;
    logic [31:0] SHIFT_SRC = 32'h0, MEM_ADDR = 32'h0, INSTR_ADDR = 32'h0, BRANCH_TARGET = 32'h0;
    logic SHIFT_DONE, FLAG_NEG, FLAG_ZERO, FLAG_CARRY, MEM_GRANT, PC_WRITE, LINK_WRITE;
    logic FAULT_RAISE, FAULT_PENDING;
    logic [1:0] FAULT_CAUSE;
    logic [31:0] SHIFT_RESULT, MEM_ADDR_OUT, PC_OPERAND, PC_TARGET, LINK_VALUE;
    int errors = 0;
    int comparisons = 0;

    // free-running 25 MHz core clock
    always #20 CLK_SYS = ~CLK_SYS;

    bscu_top dut (.CLK_SYS, .RSTN, .SHIFT_VALID, .SHIFT_OP, .SHIFT_FLAGGED, .SHIFT_SRC,
        .SHIFT_LEN, .SHIFT_DONE, .SHIFT_RESULT, .FLAGS_LOAD, .FLAGS_IN, .FLAG_NEG, .FLAG_ZERO,
        .FLAG_CARRY, .MEM_REQ, .MEM_SIZE, .MEM_ADDR, .MEM_GRANT, .MEM_ADDR_OUT, .INSTR_ADDR,
        .PC_OPERAND, .BRANCH_REQ, .BRANCH_KIND, .BRANCH_TARGET, .PC_WRITE, .PC_TARGET,
        .LINK_WRITE, .LINK_VALUE, .FAULT_RAISE, .FAULT_CAUSE, .FAULT_PENDING, .FAULT_ACK);

    // inputs move 1 ns after the edge so the design never races the bench
    task automatic step;
        @(posedge CLK_SYS);
        #1;
    endtask

    // expected {carry, result}, worked out from the shift definitions
    function automatic logic [32:0] ref_shift(input logic [1:0] op, input logic [31:0] s,
        input logic [7:0] n, input logic ci);
        logic [4:0] r;
        r = n[4:0];
        if (n == 8'h00) return {ci, s};
        case (op)
            2'h0: return (n >= 8'h20) ? {s[31], {32{s[31]}}} : {s[n-1], 32'($signed(s) >>> n)};
            2'h1: return (n > 8'h20) ? 33'h0 : (n == 8'h20) ? {s[31], 32'h0} : {s[n-1], s >> n};
            2'h2: return (n > 8'h20) ? 33'h0 : (n == 8'h20) ? {s[0], 32'h0} : {s[8'h20-n], s << n};
            default: return (r == 5'h00) ? {s[31], s} : {s[r-5'h1], (s >> r) | (s << (6'h20 - r))};
        endcase
    endfunction

    // every kind against boundary lengths, carry preloaded both ways
    task automatic t_shift_table;
        logic [7:0] lens [8] = '{8'h00, 8'h01, 8'h03, 8'h1F, 8'h20, 8'h21, 8'h28, 8'h40};
        logic [31:0] srcs [2] = '{32'h8421_C36B, 32'h7BDE_3C94};
        logic [32:0] exp_v;
        for (int op = 0; op < 4; op++) begin
            for (int k = 0; k < 16; k++) begin
                FLAGS_LOAD = 1'b1;
                FLAGS_IN = {2'h0, k[0]};
                step;
                FLAGS_LOAD = 1'b0;
                {SHIFT_VALID, SHIFT_FLAGGED, SHIFT_OP} = {2'h3, op[1:0]};
                {SHIFT_SRC, SHIFT_LEN} = {srcs[k[0]], lens[k[3:1]]};
                exp_v = ref_shift(op[1:0], srcs[k[0]], lens[k[3:1]], k[0]);
                step;
                SHIFT_VALID = 1'b0;
                `CHK(SHIFT_DONE, 1'b1)
                `CHK(SHIFT_RESULT, exp_v[31:0])
                `CHK(FLAG_CARRY, exp_v[32])
                `CHK({FLAG_NEG, FLAG_ZERO}, {exp_v[31], exp_v[31:0] == 32'h0})
            end
        end
    endtask

    // three shifts on consecutive edges, a long rotate, a long right shift, then a plain rotate
    task automatic t_back;
        {SHIFT_VALID, SHIFT_FLAGGED, SHIFT_OP, SHIFT_LEN, SHIFT_SRC} = {4'hF, 8'h24, 32'hF8};
        step;
        {SHIFT_OP, SHIFT_LEN, SHIFT_SRC} = {2'h1, 8'h21, 32'hFFFF_FFFF};
        `CHK(SHIFT_RESULT, 32'h8000_000F)
        `CHK(FLAG_CARRY, 1'b1)
        step;
        // a plain rotate must leave the cleared carry alone
        {SHIFT_FLAGGED, SHIFT_OP, SHIFT_LEN, SHIFT_SRC} = {1'b0, 2'h3, 8'h01, 32'h1};
        `CHK(SHIFT_DONE, 1'b1)
        `CHK({FLAG_CARRY, SHIFT_RESULT}, 33'h0)
        step;
        SHIFT_VALID = 1'b0;
        `CHK({FLAG_CARRY, SHIFT_RESULT}, {1'b0, 32'h8000_0000})
    endtask

    // every size at every low address pattern, faults acknowledged
    task automatic t_mem;
        logic ok;
        for (int i = 0; i < 16; i++) begin
            {MEM_REQ, MEM_SIZE, MEM_ADDR} = {1'b1, i[3:2], 30'h0800_0040, i[1:0]};
            ok = (i[3:2] == 2'h0) || (i[3:2] == 2'h1 && !i[0]) || (i[1:0] == 2'h0);
            step;
            `CHK(MEM_GRANT, ok)
            `CHK(FAULT_RAISE, !ok)
            `CHK(MEM_ADDR_OUT, MEM_ADDR)
            if (!ok) begin
                `CHK({FAULT_CAUSE, FAULT_PENDING}, 3'h3)
                MEM_REQ = 1'b0;
                FAULT_ACK = 1'b1;
                step;
                FAULT_ACK = 1'b0;
                `CHK(FAULT_PENDING, 1'b0)
            end
        end
        MEM_REQ = 1'b0;
    endtask

    // each branch kind with an odd target, then an even target refused
    task automatic t_branch;
        for (int k = 0; k < 4; k++) begin
            {BRANCH_REQ, BRANCH_KIND, BRANCH_TARGET} = {1'b1, k[1:0], 32'h0800_0201};
            INSTR_ADDR = 32'h0800_0100 + 32'(k * 8);
            step;
            `CHK({PC_WRITE, PC_TARGET}, {1'b1, 32'h0800_0200})
            `CHK(LINK_WRITE, k[0])
            if (k[0]) `CHK(LINK_VALUE, INSTR_ADDR + 32'h5)
            `CHK(PC_OPERAND, INSTR_ADDR + 32'h4)
        end
        {BRANCH_REQ, BRANCH_KIND, BRANCH_TARGET} = {1'b1, 2'h0, 32'h0800_0300};
        step;
        BRANCH_REQ = 1'b0;
        `CHK({PC_WRITE, FAULT_RAISE, FAULT_CAUSE}, 4'h6)
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // main sequence; first request only after the reset copy has drained
    initial begin
        repeat (8) @(posedge CLK_SYS);
        #1 RSTN = 1'b1;
        repeat (3) step;
        t_shift_table;
        t_back;
        t_mem;
        t_branch;
        report_and_stop;
    end

    // watchdog, well beyond the roughly 170 cycles the tests need
    initial begin
        #100000;
        errors++;
        report_and_stop;
    end
endmodule

// ==== src/bscu_pkg.sv ====
// types shared by the barrel shifter and carry unit
package bscu_pkg;

    // shift kinds, encoded 0..3 in this order on the op port
    typedef enum logic [1:0] {
        SH_ARITH_RIGHT,
        SH_LOGICAL_RIGHT,
        SH_LOGICAL_LEFT,
        SH_ROTATE_RIGHT
    } bscu_shift_op_e;

    // access sizes, encoded 0..3 in this order
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_HALF,
        SZ_WORD,
        SZ_MULTI
    } bscu_mem_size_e;

    // program counter writers, encoded 0..3 in this order
    typedef enum logic [1:0] {
        BR_EXCHANGE,
        BR_LINK_EXCHANGE,
        BR_STACK_UNLOAD,
        BR_LINK
    } bscu_branch_e;

    // fault causes, encoded 0..2 in this order
    typedef enum logic [1:0] {
        FC_NONE,
        FC_UNALIGNED,
        FC_BAD_STATE
    } bscu_fault_e;

    typedef struct packed {
        bscu_shift_op_e op;
        logic flagged;
        logic [31:0] src;
        logic [7:0] len;
    } bscu_shift_req_s;

    typedef struct packed {
        logic neg;
        logic zero;
        logic carry;
    } bscu_flags_s;

endpackage

// ==== src/bscu_regs.svh ====
// constants for the barrel shifter and carry unit
`ifndef BSCU_REGS_SVH
`define BSCU_REGS_SVH

`define BSCU_WORD_W 32
`define BSCU_LEN_W 8
`define BSCU_FULL_LEN 8'h20
`define BSCU_PC_AHEAD 32'h00000004
`define BSCU_THUMB_BIT 0
`define BSCU_RST_CARRY 1'b0
`define BSCU_RST_NEG 1'b0
`define BSCU_RST_ZERO 1'b0

`endif

// ==== src/bscu_shift_core.sv ====
// combinational 32-bit shift and rotate datapath with carry out
`timescale 1ns/100ps
`include "bscu_regs.svh"

module bscu_shift_core (
    input bscu_pkg::bscu_shift_req_s req, // operation, source and length
    input wire logic carry_in, // carry before the operation
    output logic [31:0] result, // shifted value
    output logic carry_out // carry after the operation
);

    // ------------------------------------------------------------
    // length decode helpers
    // ------------------------------------------------------------
    // true when the length empties a full word
    function automatic logic len_big(input logic [7:0] len);
        len_big = (len >= `BSCU_FULL_LEN);
    endfunction

    // index of bit n-1, for lengths 1..31
    function automatic logic [4:0] last_out(input logic [4:0] n);
        last_out = 5'(n - 5'h01);
    endfunction

    logic [4:0] n5;
    logic [63:0] rot;

    assign n5 = req.len[4:0];
    assign rot = {req.src, req.src} >> n5;

    // ------------------------------------------------------------
    // shift select
    // ------------------------------------------------------------
    always_comb begin
        result = req.src;
        carry_out = carry_in;
        if (req.len != 8'h00) begin
            case (req.op)
                bscu_pkg::SH_ARITH_RIGHT: begin
                    if (len_big(req.len)) begin
                        result = {32{req.src[31]}};
                        carry_out = req.src[31];
                    end else begin
                        result = 32'($signed(req.src) >>> n5);
                        carry_out = req.src[last_out(n5)];
                    end
                end
                bscu_pkg::SH_LOGICAL_RIGHT: begin
                    if (len_big(req.len)) begin
                        result = 32'h00000000;
                        // exactly 32 still shifts bit 31 out last
                        carry_out = (req.len == `BSCU_FULL_LEN) ? req.src[31] : 1'b0;
                    end else begin
                        result = req.src >> n5;
                        carry_out = req.src[last_out(n5)];
                    end
                end
                bscu_pkg::SH_LOGICAL_LEFT: begin
                    if (len_big(req.len)) begin
                        result = 32'h00000000;
                        carry_out = (req.len == `BSCU_FULL_LEN) ? req.src[0] : 1'b0;
                    end else begin
                        result = req.src << n5;
                        carry_out = req.src[5'(6'h20 - {1'b0, n5})];
                    end
                end
                bscu_pkg::SH_ROTATE_RIGHT: begin
                    // lengths above 32 fold by 32 repeatedly via the low five bits
                    result = rot[31:0];
                    if (n5 == 5'h00) begin
                        carry_out = req.src[31];
                    end else begin
                        carry_out = req.src[last_out(n5)];
                    end
                end
                default: begin
                    result = req.src;
                    carry_out = carry_in;
                end
            endcase
        end
    end

endmodule

// ==== src/bscu_top.sv ====
// barrel shifter, carry flag, alignment fault and program counter helpers
`timescale 1ns/100ps
`include "bscu_regs.svh"

module bscu_top (
    input wire logic CLK_SYS, // core clock, 25 MHz
    input wire logic RSTN, // asynchronous reset, active low
    // shift request
    input wire logic SHIFT_VALID, // take a shift this cycle
    input wire logic [1:0] SHIFT_OP, // shift kind
    input wire logic SHIFT_FLAGGED, // flag-setting form
    input wire logic [31:0] SHIFT_SRC, // shift_source_reg value
    input wire logic [7:0] SHIFT_LEN, // shift length, low byte
    output logic SHIFT_DONE, // result valid pulse
    output logic [31:0] SHIFT_RESULT, // shifted value
    // condition flags
    input wire logic FLAGS_LOAD, // load flags from the core
    input wire logic [2:0] FLAGS_IN, // {neg, zero, carry} to load
    output logic FLAG_NEG, // negative flag
    output logic FLAG_ZERO, // zero flag
    output logic FLAG_CARRY, // carry flag
    // memory access check
    input wire logic MEM_REQ, // access attempt
    input wire logic [1:0] MEM_SIZE, // access size
    input wire logic [31:0] MEM_ADDR, // access address
    output logic MEM_GRANT, // aligned access passed on, pulse
    output logic [31:0] MEM_ADDR_OUT, // granted or faulting address
    // program counter helpers
    input wire logic [31:0] INSTR_ADDR, // current instruction address
    output logic [31:0] PC_OPERAND, // program counter as read
    input wire logic BRANCH_REQ, // program counter write
    input wire logic [1:0] BRANCH_KIND, // kind of write
    input wire logic [31:0] BRANCH_TARGET, // target address
    output logic PC_WRITE, // target accepted pulse
    output logic [31:0] PC_TARGET, // accepted target, bit 0 cleared
    output logic LINK_WRITE, // link_register write pulse
    output logic [31:0] LINK_VALUE, // return address
    // fault reporting
    output logic FAULT_RAISE, // severe_error_exception pulse
    output logic [1:0] FAULT_CAUSE, // cause of the last fault
    output logic FAULT_PENDING, // sticky until acknowledged
    input wire logic FAULT_ACK // clear pending fault
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // reset asserts at once but releases only after two edges
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // shift datapath
    // ------------------------------------------------------------
    bscu_pkg::bscu_shift_req_s shift_req;
    bscu_pkg::bscu_flags_s flags;
    logic [31:0] next_result;
    logic next_carry;

    // pack the request so the core sees one bundle
    always_comb begin
        shift_req.op = bscu_pkg::bscu_shift_op_e'(SHIFT_OP);
        shift_req.flagged = SHIFT_FLAGGED;
        shift_req.src = SHIFT_SRC;
        shift_req.len = SHIFT_LEN;
    end

    bscu_shift_core u_core (
        .req(shift_req),
        .carry_in(flags.carry),
        .result(next_result),
        .carry_out(next_carry)
    );

    // result and done pulse, one cycle after the request
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            SHIFT_DONE <= 1'b0;
            SHIFT_RESULT <= 32'h00000000;
        end else begin
            SHIFT_DONE <= SHIFT_VALID;
            if (SHIFT_VALID) begin
                SHIFT_RESULT <= next_result;
            end
        end
    end

    // ------------------------------------------------------------
    // condition flags
    // ------------------------------------------------------------
    // a flagged shift wins over a flag load in the same cycle,
    // so the carry produced by the shift is never lost
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            flags.neg <= `BSCU_RST_NEG;
            flags.zero <= `BSCU_RST_ZERO;
            flags.carry <= `BSCU_RST_CARRY;
        end else if (SHIFT_VALID && SHIFT_FLAGGED) begin
            flags.neg <= next_result[31];
            flags.zero <= (next_result == 32'h00000000);
            // the core keeps carry unchanged for zero length
            flags.carry <= next_carry;
        end else if (FLAGS_LOAD) begin
            flags.neg <= FLAGS_IN[2];
            flags.zero <= FLAGS_IN[1];
            flags.carry <= FLAGS_IN[0];
        end
    end

    // outputs read the flag flops directly; a second copy could drift apart
    assign FLAG_NEG = flags.neg;
    assign FLAG_ZERO = flags.zero;
    assign FLAG_CARRY = flags.carry;

    // ------------------------------------------------------------
    // alignment check
    // ------------------------------------------------------------
    // true when the address suits the access size
    function automatic logic is_aligned(input logic [1:0] size, input logic [1:0] low);
        case (bscu_pkg::bscu_mem_size_e'(size))
            bscu_pkg::SZ_BYTE: is_aligned = 1'b1;
            bscu_pkg::SZ_HALF: is_aligned = (low[0] == 1'b0);
            bscu_pkg::SZ_WORD: is_aligned = (low == 2'h0);
            bscu_pkg::SZ_MULTI: is_aligned = (low == 2'h0);
            default: is_aligned = 1'b0;
        endcase
    endfunction

    logic mem_ok;
    logic mem_bad;

    assign mem_ok = MEM_REQ && is_aligned(MEM_SIZE, MEM_ADDR[1:0]);
    assign mem_bad = MEM_REQ && !is_aligned(MEM_SIZE, MEM_ADDR[1:0]);

    // an unaligned access is never passed on, only faulted
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            MEM_GRANT <= 1'b0;
            MEM_ADDR_OUT <= 32'h00000000;
        end else begin
            MEM_GRANT <= mem_ok;
            if (MEM_REQ) begin
                MEM_ADDR_OUT <= MEM_ADDR;
            end
        end
    end

    // ------------------------------------------------------------
    // program counter and link value
    // ------------------------------------------------------------
    // address of the instruction that follows, state bit not set here
    function automatic logic [31:0] ahead(input logic [31:0] addr);
        ahead = 32'(addr + `BSCU_PC_AHEAD);
    endfunction

    logic is_link;
    logic is_exch;
    logic bad_target;

    assign is_link = (bscu_pkg::bscu_branch_e'(BRANCH_KIND) == bscu_pkg::BR_LINK)
        || (bscu_pkg::bscu_branch_e'(BRANCH_KIND) == bscu_pkg::BR_LINK_EXCHANGE);
    assign is_exch = (bscu_pkg::bscu_branch_e'(BRANCH_KIND) != bscu_pkg::BR_LINK);
    // a cleared state bit would select an unsupported instruction set
    assign bad_target = BRANCH_REQ && is_exch && !BRANCH_TARGET[`BSCU_THUMB_BIT];

    // operand view of the program counter, refreshed every cycle
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            PC_OPERAND <= 32'h00000000;
        end else begin
            PC_OPERAND <= ahead(INSTR_ADDR);
        end
    end

    // target and return address, registered with the branch
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            PC_WRITE <= 1'b0;
            PC_TARGET <= 32'h00000000;
            LINK_WRITE <= 1'b0;
            LINK_VALUE <= 32'h00000000;
        end else begin
            PC_WRITE <= BRANCH_REQ && !bad_target;
            LINK_WRITE <= BRANCH_REQ && is_link && !bad_target;
            if (BRANCH_REQ) begin
                // fetch addresses are halfword aligned, so bit 0 is dropped
                PC_TARGET <= {BRANCH_TARGET[31:1], 1'b0};
            end
            if (BRANCH_REQ && is_link) begin
                LINK_VALUE <= ahead(INSTR_ADDR) | 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------
    // fault reporting
    // ------------------------------------------------------------
    // unaligned access takes priority in the cause when both occur
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            FAULT_RAISE <= 1'b0;
            FAULT_CAUSE <= bscu_pkg::FC_NONE;
        end else begin
            FAULT_RAISE <= mem_bad || bad_target;
            if (mem_bad) begin
                FAULT_CAUSE <= bscu_pkg::FC_UNALIGNED;
            end else if (bad_target) begin
                FAULT_CAUSE <= bscu_pkg::FC_BAD_STATE;
            end
        end
    end

    // sticky pending bit; a new fault beats an acknowledge
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            FAULT_PENDING <= 1'b0;
        end else if (mem_bad || bad_target) begin
            FAULT_PENDING <= 1'b1;
        end else if (FAULT_ACK) begin
            FAULT_PENDING <= 1'b0;
        end
    end

endmodule
